//--- hdl/ufm_pkg.sv
package ufm_pkg;
   // Mode register: printed word index, byte address is four times it
   localparam logic [31:0] MODE_IDX  = 32'h0000FF2F;
   localparam logic [31:0] MODE_ADDR = {MODE_IDX[29:0], 2'b00};
   localparam logic [31:0] TXB_ADDR  = 32'h0003FCC0;
   localparam logic [31:0] RXB_ADDR  = 32'h0003FCC4;
   localparam logic [31:0] ERR_ADDR  = 32'h0003FCC8;
   localparam logic [31:0] TXS_ADDR  = 32'h0003FCCC;
   localparam logic [31:0] BCK_ADDR  = 32'h0003FCD0;
   // Mode register fields
   localparam int MD_PWR = 7;
   localparam int MD_TXE = 6;
   localparam int MD_RXE = 5;
   localparam int MD_PHI = 4;
   localparam int MD_PLO = 3;
   localparam int MD_CL  = 2;
   localparam int MD_SL  = 1;
   localparam int MD_ISR = 0;
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] BCK_RST  = 8'h0F;
   // Error and transmit status fields
   localparam int ER_PE   = 2;
   localparam int ER_FE   = 1;
   localparam int ER_OVE  = 0;
   localparam int TS_TXBF = 1;
   localparam int TS_TXSF = 0;
   // Parity modes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;
   // Base ticks per bit and bit counts
   localparam logic [3:0] BIT_LAST  = 4'hF;
   localparam logic [3:0] HALF_LAST = 4'h7;
   localparam logic [3:0] LAST7     = 4'h6;
   localparam logic [3:0] LAST8     = 4'h7;
   localparam int HT_ACT = 1;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
      TX_PAR  = 5'h08, TX_STOP  = 5'h10
   } ufm_tx_st_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
      RX_PAR  = 5'h08, RX_STOP  = 5'h10
   } ufm_rx_st_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } ufm_ahb_in_t;
   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } ufm_ahb_out_t;

   typedef struct packed {
      logic [7:0]  mode;
      logic [7:0]  bdiv;
      logic [7:0]  txb;
      logic [7:0]  rxb;
      logic [2:0]  err;
      logic        txbf;
      logic        txsf;
      logic        rx_full;
      logic        wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
      logic        hrdy;
      logic [7:0]  div_cnt;
      logic        tick;
      logic        tx_en_s;
      logic        rx_en_s;
      logic [2:0]  rx_sync;
      logic        rx_lvl;
      ufm_tx_st_t  tx_st;
      logic [3:0]  tx_cnt;
      logic [3:0]  tx_bit;
      logic [7:0]  tx_sh;
      logic        tx_par;
      logic        txd;
      ufm_rx_st_t  rx_st;
      logic [3:0]  rx_cnt;
      logic [3:0]  rx_bit;
      logic [7:0]  rx_sh;
      logic        rx_par;
      logic        irq_done;
      logic        irq_err;
   } ufm_state_t;
endpackage : ufm_pkg

//--- hdl/ufm_uart_mode_control.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Power and receive enable with low line starts a reception.
// - Enables sync to base clock; two base clocks before re-enabling.
// - Receiver checks exactly one stop bit regardless of stop setting.
// - Power off stops clock and clears status, flags and receive buffer.
// - Power off drives transmit line high, forces receive input high.
// - Transmit enable low resets transmitter; high enables it.
// - Receive enable low resets receiver; high enables it.
// - Parity field: none, zero, odd or even for send and check.
// - Zero parity mode never sets the parity error flag.
// - Character length bit selects seven or eight data bits.
// - Stop setting appends one or two stop bits on transmit.
// - Routing bit sends receive errors to error or done interrupt.
// - Mode register is 8 bits, read/write, resets to 01H.
// - Missing stop bit and overrun set errors; overrun data dropped.
module ufm_uart_mode_control #(
   parameter logic [7:0] BDIV_RESET = ufm_pkg::BCK_RST
) (
   input  wire logic                  I_CLK,
   input  wire logic                  I_RST_N,
   input  wire ufm_pkg::ufm_ahb_in_t  I_AHB,
   output ufm_pkg::ufm_ahb_out_t      O_AHB,
   input  wire logic                  I_RXD,
   output logic                       O_TXD,
   output logic                       O_RX_DONE_IRQ,
   output logic                       O_RX_ERR_IRQ
);

   ufm_pkg::ufm_state_t s_r;
   ufm_pkg::ufm_state_t s_nxt;
   logic                rx_in;
   logic                pwr;
   logic                a_ph;
   logic [7:0]          rx_data;
   logic [2:0]          rx_err;
   logic [1:0]          pmode;

   // Parity bit for the chosen mode over 7 or 8 data bits
   function automatic logic par_of(input logic [1:0] pm,
                                   input logic [7:0] d,
                                   input logic       cl);
      logic x;
      x = ^(cl ? d : {1'b0, d[6:0]});
      case (pm)
         ufm_pkg::PAR_ODD:  par_of = ~x;
         ufm_pkg::PAR_EVEN: par_of = x;
         default:           par_of = 1'b0;
      endcase
   endfunction : par_of

   // Index of the last data bit
   function automatic logic [3:0] last_bit(input logic cl);
      last_bit = cl ? ufm_pkg::LAST8 : ufm_pkg::LAST7;
   endfunction : last_bit

   // Read value of a mapped register, zero elsewhere
   function automatic logic [31:0] rd_mux(input logic [31:0]         a,
                                          input ufm_pkg::ufm_state_t st);
      logic [31:0] v;
      v = 32'h00000000;
      if (a == ufm_pkg::MODE_ADDR) begin
         v[7:0] = st.mode;
      end else if (a == ufm_pkg::RXB_ADDR) begin
         v[7:0] = st.rxb;
      end else if (a == ufm_pkg::ERR_ADDR) begin
         v[2:0] = st.err;
      end else if (a == ufm_pkg::TXS_ADDR) begin
         v[ufm_pkg::TS_TXBF] = st.txbf;
         v[ufm_pkg::TS_TXSF] = st.txsf;
      end else if (a == ufm_pkg::TXB_ADDR) begin
         v[7:0] = st.txb;
      end else if (a == ufm_pkg::BCK_ADDR) begin
         v[7:0] = st.bdiv;
      end
      rd_mux = v;
   endfunction : rd_mux

   // Whole next state in one place
   always_comb begin
      s_nxt = s_r;
      s_nxt.irq_done = 1'b0;
      s_nxt.irq_err = 1'b0;
      s_nxt.tick = 1'b0;
      s_nxt.hrdy = 1'b1;
      rx_data = 8'h00;
      rx_err = 3'h0;
      pwr = s_r.mode[ufm_pkg::MD_PWR];
      pmode = s_r.mode[ufm_pkg::MD_PHI:ufm_pkg::MD_PLO];
      a_ph = I_AHB.hsel & I_AHB.htrans[ufm_pkg::HT_ACT] & I_AHB.hready;

      // Pin synchroniser; a level counts once stages two and three agree
      s_nxt.rx_sync = {s_r.rx_sync[1:0], I_RXD};
      if (s_r.rx_sync[1] == s_r.rx_sync[2]) begin
         s_nxt.rx_lvl = s_r.rx_sync[2];
      end
      rx_in = pwr ? s_r.rx_lvl : 1'b1;

      // Base clock divider, cleared to zero while the operation clock is stopped
      if (pwr) begin
         if (s_r.div_cnt >= s_r.bdiv) begin
            s_nxt.div_cnt = 8'h00;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.div_cnt = s_r.div_cnt + 8'h01;
         end
      end else begin
         s_nxt.div_cnt = 8'h00;
      end

      // Data phase of a write taken last cycle
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend) begin
         if (s_r.wr_addr == ufm_pkg::MODE_ADDR) begin
            s_nxt.mode = I_AHB.hwdata[7:0];
         end else if (s_r.wr_addr == ufm_pkg::TXB_ADDR) begin
            // Buffer only fills once the enable has reached the base clock
            if (s_r.tx_en_s) begin
               s_nxt.txb = I_AHB.hwdata[7:0];
               s_nxt.txbf = 1'b1;
            end
         end else if (s_r.wr_addr == ufm_pkg::BCK_ADDR) begin
            s_nxt.bdiv = I_AHB.hwdata[7:0];
         end
      end

      // Address phase: reads see the write just applied
      if (a_ph) begin
         if (I_AHB.hwrite) begin
            s_nxt.wr_pend = 1'b1;
            s_nxt.wr_addr = I_AHB.haddr;
         end else begin
            s_nxt.rdata = rd_mux(I_AHB.haddr, s_nxt);
            // Read clears; hardware sets below win in the same cycle
            if (I_AHB.haddr == ufm_pkg::ERR_ADDR) begin
               s_nxt.err = 3'h0;
            end
            if (I_AHB.haddr == ufm_pkg::RXB_ADDR) begin
               s_nxt.rx_full = 1'b0;
            end
         end
      end

      // Enables taken over only on a base clock tick, except power off clears them at once
      if (s_r.tick) begin
         s_nxt.tx_en_s = s_r.mode[ufm_pkg::MD_TXE] & pwr;
         s_nxt.rx_en_s = s_r.mode[ufm_pkg::MD_RXE] & pwr;
      end

      // Transmitter, one step per base tick
      if (s_r.tick && s_r.tx_en_s) begin
         s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
         case (s_r.tx_st)
            ufm_pkg::TX_IDLE: begin
               s_nxt.tx_cnt = 4'h0;
               if (s_r.txbf) begin
                  s_nxt.tx_sh = s_r.txb;
                  s_nxt.tx_par = par_of(pmode, s_r.txb,
                                        s_r.mode[ufm_pkg::MD_CL]);
                  s_nxt.txbf = 1'b0;
                  s_nxt.txsf = 1'b1;
                  s_nxt.tx_st = ufm_pkg::TX_START;
               end
            end
            ufm_pkg::TX_START: begin
               if (s_r.tx_cnt == ufm_pkg::BIT_LAST) begin
                  s_nxt.tx_bit = 4'h0;
                  s_nxt.tx_st = ufm_pkg::TX_DATA;
               end
            end
            ufm_pkg::TX_DATA: begin
               if (s_r.tx_cnt == ufm_pkg::BIT_LAST) begin
                  s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                  s_nxt.tx_bit = s_r.tx_bit + 4'h1;
                  if (s_r.tx_bit == last_bit(s_r.mode[ufm_pkg::MD_CL])) begin
                     s_nxt.tx_bit = 4'h0;
                     if (pmode == ufm_pkg::PAR_NONE) begin
                        s_nxt.tx_st = ufm_pkg::TX_STOP;
                     end else begin
                        s_nxt.tx_st = ufm_pkg::TX_PAR;
                     end
                  end
               end
            end
            ufm_pkg::TX_PAR: begin
               if (s_r.tx_cnt == ufm_pkg::BIT_LAST) begin
                  s_nxt.tx_bit = 4'h0;
                  s_nxt.tx_st = ufm_pkg::TX_STOP;
               end
            end
            ufm_pkg::TX_STOP: begin
               if (s_r.tx_cnt == ufm_pkg::BIT_LAST) begin
                  // Second stop bit only when asked for
                  if (s_r.mode[ufm_pkg::MD_SL] && s_r.tx_bit == 4'h0) begin
                     s_nxt.tx_bit = 4'h1;
                  end else begin
                     s_nxt.txsf = 1'b0;
                     s_nxt.tx_st = ufm_pkg::TX_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.tx_st = ufm_pkg::TX_IDLE;
            end
         endcase
      end

      // Receiver, one step per base tick
      if (s_r.tick && s_r.rx_en_s) begin
         s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
         case (s_r.rx_st)
            ufm_pkg::RX_IDLE: begin
               s_nxt.rx_cnt = 4'h0;
               // Level, not edge: a line already low starts a frame
               if (!rx_in) begin
                  s_nxt.rx_st = ufm_pkg::RX_START;
               end
            end
            ufm_pkg::RX_START: begin
               if (s_r.rx_cnt == ufm_pkg::HALF_LAST) begin
                  s_nxt.rx_cnt = 4'h0;
                  s_nxt.rx_bit = 4'h0;
                  s_nxt.rx_st = rx_in ? ufm_pkg::RX_IDLE : ufm_pkg::RX_DATA;
               end
            end
            ufm_pkg::RX_DATA: begin
               if (s_r.rx_cnt == ufm_pkg::BIT_LAST) begin
                  s_nxt.rx_sh = {rx_in, s_r.rx_sh[7:1]};
                  s_nxt.rx_bit = s_r.rx_bit + 4'h1;
                  if (s_r.rx_bit == last_bit(s_r.mode[ufm_pkg::MD_CL])) begin
                     if (pmode == ufm_pkg::PAR_NONE) begin
                        s_nxt.rx_st = ufm_pkg::RX_STOP;
                     end else begin
                        s_nxt.rx_st = ufm_pkg::RX_PAR;
                     end
                  end
               end
            end
            ufm_pkg::RX_PAR: begin
               if (s_r.rx_cnt == ufm_pkg::BIT_LAST) begin
                  s_nxt.rx_par = rx_in;
                  s_nxt.rx_st = ufm_pkg::RX_STOP;
               end
            end
            ufm_pkg::RX_STOP: begin
               // Only the first stop bit is ever checked
               if (s_r.rx_cnt == ufm_pkg::BIT_LAST) begin
                  rx_data = s_r.mode[ufm_pkg::MD_CL] ? s_r.rx_sh
                                                     : {1'b0, s_r.rx_sh[7:1]};
                  rx_err[ufm_pkg::ER_FE] = ~rx_in;
                  rx_err[ufm_pkg::ER_OVE] = s_r.rx_full;
                  // Zero parity and no parity are never judged
                  if (pmode == ufm_pkg::PAR_ODD || pmode == ufm_pkg::PAR_EVEN) begin
                     rx_err[ufm_pkg::ER_PE] =
                        par_of(pmode, rx_data, s_r.mode[ufm_pkg::MD_CL]) != s_r.rx_par;
                  end
                  s_nxt.err = s_nxt.err | rx_err;
                  if (!s_r.rx_full) begin
                     s_nxt.rxb = rx_data;
                     s_nxt.rx_full = 1'b1;
                  end
                  if (rx_err != 3'h0 && !s_r.mode[ufm_pkg::MD_ISR]) begin
                     s_nxt.irq_err = 1'b1;
                  end else begin
                     s_nxt.irq_done = 1'b1;
                  end
                  s_nxt.rx_st = ufm_pkg::RX_IDLE;
               end
            end
            default: begin
               s_nxt.rx_st = ufm_pkg::RX_IDLE;
            end
         endcase
      end

      // Transmit side held in reset while disabled
      if (!s_r.tx_en_s) begin
         s_nxt.tx_st = ufm_pkg::TX_IDLE;
         s_nxt.tx_cnt = 4'h0;
         s_nxt.txsf = 1'b0;
         if (!s_nxt.tx_en_s) begin
            s_nxt.txbf = 1'b0;
         end
      end

      // Receive side held in reset while disabled
      if (!s_r.rx_en_s) begin
         s_nxt.rx_st = ufm_pkg::RX_IDLE;
         s_nxt.rx_cnt = 4'h0;
         s_nxt.err = 3'h0;
      end

      // Power off clears the channel at once, not on a tick
      if (!pwr) begin
         s_nxt.tx_en_s = 1'b0;
         s_nxt.rx_en_s = 1'b0;
         s_nxt.err = 3'h0;
         s_nxt.txbf = 1'b0;
         s_nxt.txsf = 1'b0;
         s_nxt.rxb = 8'h00;
         s_nxt.rx_full = 1'b0;
         s_nxt.tx_st = ufm_pkg::TX_IDLE;
         s_nxt.rx_st = ufm_pkg::RX_IDLE;
         s_nxt.irq_done = 1'b0;
         s_nxt.irq_err = 1'b0;
      end

      // Line level follows the next transmit state
      case (s_nxt.tx_st)
         ufm_pkg::TX_START: s_nxt.txd = 1'b0;
         ufm_pkg::TX_DATA:  s_nxt.txd = s_nxt.tx_sh[0];
         ufm_pkg::TX_PAR:   s_nxt.txd = s_nxt.tx_par;
         default:           s_nxt.txd = 1'b1;
      endcase
      if (!pwr) begin
         s_nxt.txd = 1'b1;
      end
   end

   // State register; reset is synchronous
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         s_r         <= '0;
         s_r.mode    <= ufm_pkg::MODE_RST;
         s_r.bdiv    <= BDIV_RESET;
         s_r.hrdy    <= 1'b1;
         s_r.rx_sync <= 3'h7;
         s_r.rx_lvl  <= 1'b1;
         s_r.txd     <= 1'b1;
         s_r.tx_st   <= ufm_pkg::TX_IDLE;
         s_r.rx_st   <= ufm_pkg::RX_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register; no wait states
   assign O_AHB.hreadyout = s_r.hrdy;
   assign O_AHB.hresp     = s_r.wr_pend & 1'b0;
   assign O_AHB.hrdata    = s_r.rdata;
   assign O_TXD           = s_r.txd;
   assign O_RX_DONE_IRQ   = s_r.irq_done;
   assign O_RX_ERR_IRQ    = s_r.irq_err;

endmodule : ufm_uart_mode_control

//--- verif/ufm_uart_mode_control_props.sv
`timescale 1ns/1ps
module ufm_uart_mode_control_props (
   input wire logic                  I_CLK,
   input wire logic                  I_RST_N,
   input wire ufm_pkg::ufm_ahb_in_t  I_AHB,
   input wire ufm_pkg::ufm_ahb_out_t O_AHB,
   input wire logic                  I_RXD,
   input wire logic                  O_TXD,
   input wire logic                  O_RX_DONE_IRQ,
   input wire logic                  O_RX_ERR_IRQ
);
   logic [7:0] mode_r;
   logic       mode_wr_r;
   logic [7:0] low_cnt_r;
   logic       go;
   logic       any_irq;

   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   // Accepted address phase, any interrupt pulse
   assign go      = I_AHB.hsel & I_AHB.htrans[1] & I_AHB.hready;
   assign any_irq = O_RX_DONE_IRQ | O_RX_ERR_IRQ;

   // Mode shadow from bus writes; run length of a low serial line
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         mode_r    <= 8'h01;
         mode_wr_r <= 1'b0;
         low_cnt_r <= 8'h00;
      end else begin
         mode_wr_r <= go & I_AHB.hwrite & (I_AHB.haddr == ufm_pkg::MODE_ADDR);
         if (mode_wr_r) begin
            mode_r <= I_AHB.hwdata[7:0];
         end
         low_cnt_r <= O_TXD ? 8'h00 : (low_cnt_r == 8'hFF ? low_cnt_r : low_cnt_r + 8'h01);
      end
   end

   okay_resp_a: assert property (O_AHB.hreadyout && !O_AHB.hresp)
      else $error("bus answer not ready or not okay");
   mode_read_a: assert property (go && !I_AHB.hwrite
      && I_AHB.haddr == ufm_pkg::MODE_ADDR |=> O_AHB.hrdata == {24'h000000, mode_r})
      else $error("mode read differs");
   txd_off_a: assert property (!mode_r[7] |-> ##2 O_TXD)
      else $error("serial output low while unpowered");
   fall_pwr_a: assert property ($fell(O_TXD) |-> $past(mode_r[7], 2))
      else $error("serial output fell without power");
   irq_excl_a: assert property (!(O_RX_DONE_IRQ && O_RX_ERR_IRQ))
      else $error("both receive interrupts at once");
   err_route_a: assert property (O_RX_ERR_IRQ |-> !mode_r[0])
      else $error("error interrupt with routing set");
   irq_pulse_a: assert property (any_irq |=> !any_irq)
      else $error("interrupt longer than one cycle");
   off_quiet_a: assert property (!mode_r[7] && !$past(mode_r[7]) && !$past(mode_r[7], 2)
      |-> !any_irq) else $error("interrupt while unpowered");
   bit_len_a: assert property ($rose(O_TXD) && mode_r[7] |-> low_cnt_r >= 8'h10)
      else $error("low run shorter than one bit");

   done_c: cover property (O_RX_DONE_IRQ);
   err_c: cover property (O_RX_ERR_IRQ);
   frame_c: cover property ($fell(O_TXD));
endmodule : ufm_uart_mode_control_props

bind ufm_uart_mode_control ufm_uart_mode_control_props i_props (
   .I_CLK         (I_CLK),
   .I_RST_N       (I_RST_N),
   .I_AHB         (I_AHB),
   .O_AHB         (O_AHB),
   .I_RXD         (I_RXD),
   .O_TXD         (O_TXD),
   .O_RX_DONE_IRQ (O_RX_DONE_IRQ),
   .O_RX_ERR_IRQ  (O_RX_ERR_IRQ)
);

//--- verif/ufm_serial_node.sv
`timescale 1ns/1ps
module ufm_serial_node #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic i_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   int cyc;

   // Pulled-up line rests high between frames
   initial o_rxd = 1'b1;
   initial cyc = 0;

   // Cycle count for timing of start bits; non-blocking so readers at the edge agree
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
   end

   // Start bit, the given bits in order, then idle high again
   task automatic send(input logic [11:0] bits, input int len);
      @(posedge i_clk);
      o_rxd <= 1'b0;
      repeat (BIT_CLKS) @(posedge i_clk);
      for (int i = 0; i < len; i++) begin
         o_rxd <= bits[i];
         repeat (BIT_CLKS) @(posedge i_clk);
      end
      o_rxd <= 1'b1;
   endtask : send

   // Waits for a start bit, then samples each bit in its middle
   task automatic grab(input int len, output logic [11:0] bits, output int t_fall);
      int k;
      bits = 12'hFFF;
      k = 0;
      while (i_txd !== 1'b0 && k < 4000) begin
         @(posedge i_clk);
         k++;
      end
      t_fall = cyc;
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int i = 0; i < len; i++) begin
         repeat (BIT_CLKS) @(posedge i_clk);
         bits[i] = i_txd;
      end
   endtask : grab
endmodule : ufm_serial_node

//--- verif/ufm_uart_mode_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module ufm_uart_mode_control_tb;
   logic                  clk;
   logic                  rst_n;
   ufm_pkg::ufm_ahb_in_t  ahb_drv;
   ufm_pkg::ufm_ahb_in_t  ahb_in;
   ufm_pkg::ufm_ahb_out_t ahb_out;
   logic                  rxd;
   logic                  txd;
   logic                  irq_done;
   logic                  irq_err;
   logic [7:0]            cur;
   int                    n_mismatch = 0;
   int                    cmp_count = 0;
   int                    n_done = 0;
   int                    n_err = 0;
   int                    cyc = 0;
   int                    seed = 2771;

   // Divisor zero: one base tick per clock keeps frames short
   ufm_uart_mode_control #(.BDIV_RESET(8'h00)) i_dut (
      .I_CLK         (clk),
      .I_RST_N       (rst_n),
      .I_AHB         (ahb_in),
      .O_AHB         (ahb_out),
      .I_RXD         (rxd),
      .O_TXD         (txd),
      .O_RX_DONE_IRQ (irq_done),
      .O_RX_ERR_IRQ  (irq_err)
   );
   ufm_serial_node i_node (
      .i_clk (clk),
      .i_txd (txd),
      .o_rxd (rxd)
   );

   // Single slave: its ready is the bus ready
   always_comb begin
      ahb_in = ahb_drv;
      ahb_in.hready = ahb_out.hreadyout;
   end

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Interrupt pulse counts and the cycle budget against hangs
   always @(posedge clk) begin
      cyc++;
      n_done += int'(irq_done === 1'b1);
      n_err += int'(irq_err === 1'b1);
      if (cyc > 40000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // No local limit: only the cycle budget ends a stuck wait
   task automatic wait_rdy();
      do begin
         @(posedge clk);
      end while (ahb_out.hreadyout !== 1'b1);
   endtask : wait_rdy

   // One single word transfer, address phase then data phase
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      ahb_drv.hsel   <= 1'b1;
      ahb_drv.haddr  <= a;
      ahb_drv.htrans <= 2'h2;
      ahb_drv.hwrite <= wr;
      ahb_drv.hsize  <= 3'h2;
      wait_rdy();
      ahb_drv.htrans <= 2'h0;
      ahb_drv.hwdata <= wd;
      wait_rdy();
      rd = ahb_out.hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] v;
      xfer(1'b1, a, d, v);
   endtask : wr

   task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h00000000, v);
      `CHK(nm, exp, v)
   endtask : rchk

   // Enables off, settings changed while powered, enables back on
   task automatic cfg(input logic [7:0] m);
      wr(ufm_pkg::MODE_ADDR, {24'h000000, 8'h80 | (cur & 8'h1F)});
      repeat (3) @(posedge clk);
      wr(ufm_pkg::MODE_ADDR, {24'h000000, 8'h80 | m});
      wr(ufm_pkg::MODE_ADDR, {24'h000000, 8'hE0 | m});
      repeat (3) @(posedge clk);
      cur = m;
   endtask : cfg

   // Bits after the start bit: data, parity, then idle high
   function automatic logic [11:0] fbits(input logic [7:0] d, input logic [7:0] m);
      logic [11:0] b;
      int          n;
      logic        p;
      n = m[2] ? 8 : 7;
      p = m[2] ? ^d : ^d[6:0];
      b = 12'hFFF;
      for (int j = 0; j < n; j++) begin
         b[j] = d[j];
      end
      if (m[4:3] != 2'h0) begin
         b[n] = (m[4:3] == 2'h1) ? 1'b0 : (m[4:3] == 2'h2) ? ~p : p;
      end
      return b;
   endfunction : fbits

   function automatic int flen(input logic [7:0] m);
      return (m[2] ? 9 : 8) + int'(m[4:3] != 2'h0) + int'(m[1]);
   endfunction : flen

   initial begin
      logic [7:0]  d1;
      logic [7:0]  d2;
      logic [7:0]  m;
      logic [11:0] f1;
      logic [11:0] f2;
      logic [11:0] e1;
      logic [11:0] msk;
      logic [31:0] v;
      int          t1;
      int          t2;
      int          len;
      int          b_done;
      int          b_err;
      ahb_drv = '0;
      rst_n = 1'b0;
      cur = 8'h01;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset value, read/write, read-only and unmapped places
      rchk("mode_rst", ufm_pkg::MODE_ADDR, 32'h00000001);
      wr(ufm_pkg::MODE_ADDR, 32'hFFFFFF1E);
      rchk("mode_rw", ufm_pkg::MODE_ADDR, 32'h0000001E);
      cur = 8'h1E;
      wr(ufm_pkg::ERR_ADDR, 32'h00000007);
      rchk("err_ro", ufm_pkg::ERR_ADDR, 32'h00000000);
      rchk("unmapped", 32'h00000100, 32'h00000000);
      // Every parity, length and stop setting: two frames out, one in
      for (int i = 0; i < 16; i++) begin
         m = {3'h0, i[3:0], 1'b0};
         cfg(m);
         d1 = 8'($random(seed));
         d2 = 8'($random(seed));
         len = flen(m);
         msk = 12'hFFF >> (12 - len);
         fork
            begin
               i_node.grab(len, f1, t1);
               i_node.grab(len, f2, t2);
            end
            begin
               wr(ufm_pkg::TXB_ADDR, {24'h000000, d1});
               do begin
                  xfer(1'b0, ufm_pkg::TXS_ADDR, 32'h00000000, v);
               end while (v[1] !== 1'b0 && cyc < 39000);
               wr(ufm_pkg::TXB_ADDR, {24'h000000, d2});
            end
         join
         `CHK("tx1", fbits(d1, m) & msk, f1 & msk)
         `CHK("tx2", fbits(d2, m) & msk, f2 & msk)
         t2 = t2 - t1 - (len + 1) * 16;
         `CHK("gap", 1'b1, t2 >= 0 && t2 <= 4)
         b_done = n_done;
         b_err = n_err;
         i_node.send(fbits(d1, m), flen(m & 8'hFD));
         repeat (30) @(posedge clk);
         `CHK("done_irq", b_done + 1, n_done)
         `CHK("err_irq", b_err, n_err)
         rchk("rx_data", ufm_pkg::RXB_ADDR, {24'h000000, d1 & (m[2] ? 8'hFF : 8'h7F)});
         rchk("rx_err", ufm_pkg::ERR_ADDR, 32'h00000000);
      end
      // Bad parity judged, routed both ways, ignored in zero mode; broken stop
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 8'h14 : (i == 1) ? 8'h15 : (i == 2) ? 8'h0C : 8'h04;
         cfg(m);
         d1 = 8'($random(seed));
         e1 = fbits(d1, m);
         e1[8] = (i < 3) ? ~e1[8] : 1'b0;
         b_done = n_done;
         b_err = n_err;
         i_node.send(e1, flen(m));
         repeat (40) @(posedge clk);
         `CHK("done_irq", b_done + int'(i == 1 || i == 2), n_done)
         `CHK("err_irq", b_err + int'(i == 0 || i == 3), n_err)
         v = (i == 2) ? 32'h00000000 : (i == 3) ? 32'h00000002 : 32'h00000004;
         rchk("err_flags", ufm_pkg::ERR_ADDR, v);
         xfer(1'b0, ufm_pkg::RXB_ADDR, 32'h00000000, v);
      end
      // Two frames with one stop each under two-stop setting, none read between
      cfg(8'h06);
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      b_err = n_err;
      i_node.send(fbits(d1, 8'h04), 9);
      i_node.send(fbits(d2, 8'h04), 9);
      repeat (40) @(posedge clk);
      `CHK("ovr_irq", b_err + 1, n_err)
      rchk("ovr_data", ufm_pkg::RXB_ADDR, {24'h000000, d1});
      rchk("ovr_flag", ufm_pkg::ERR_ADDR, 32'h00000001);
      // Power dropped in mid-frame, transmit enable cleared by the same write
      wr(ufm_pkg::TXB_ADDR, 32'h00000000);
      repeat (60) @(posedge clk);
      `CHK("txd_busy", 1'b0, txd)
      wr(ufm_pkg::MODE_ADDR, 32'h00000000);
      repeat (3) @(posedge clk);
      `CHK("txd_off", 1'b1, txd)
      rchk("rxb_off", ufm_pkg::RXB_ADDR, 32'h00000000);
      rchk("txs_off", ufm_pkg::TXS_ADDR, 32'h00000000);
      test_done();
   end
endmodule : ufm_uart_mode_control_tb
